//--- pms_power_mode_sequencer.sv
// Behaviour
// - in the reset state every register returns to its default value
// - low external reset or active power-on reset forces the reset state
// - power-on reset comes from supply monitor; its release leads to standby
// - the run request bit is zero after power-on reset
// - with reset inactive and run request zero, sit in standby, all off
// - writes accepted in standby; bits other than run request act once startup completes
// - run request set starts startup, enabling reference, bias, oscillator
// - startup waits ten milliseconds for the oscillator to settle
// - thermal shutdown disables operation and holds the startup state
// - soft-start runs the converter in low-current mode for twenty ms
// - all LED outputs are forced off throughout soft-start
// - soft-start entered from startup with boost on, or boost written on
// - in normal mode registers take writes in any order, any bits
// - boost enable zero puts the converter in standby, chip keeps running
// - after soft-start the converter changes to normal PWM
// - active load applied while its enable bit is one and the converter runs
// - a minimum width switch pulse every cycle, no pulse skipping
// - eight bit output setting selects one of the voltage steps
// - switching duty cycle limited by digital logic
// - internal oscillator clocks the converter switching and the startup and soft-start delays
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_power_mode_sequencer
	import pms_pkg::*;
#(
	parameter int OSC_DIV = `PMS_OSC_DIV,
	parameter int STARTUP_TICKS = `PMS_STARTUP_TICKS,
	parameter int SOFTSTART_TICKS = `PMS_SOFTSTART_TICKS,
	parameter int CNT_W = 15
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// reset and protection pins
	input wire logic external_reset_low_n,
	input wire logic porActive,
	input wire logic thermal_shutdown,
	// power control outputs
	output logic refBiasOscEnable,
	output logic chipEnable,
	output logic ledForceOff,
	output logic boostSwitch,
	output logic lowCurrentPwm,
	output logic activeLoadOn,
	output logic [2:0] seqState
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	if (OSC_DIV < 2 || OSC_DIV > 255) begin : gBadDiv
		$error("OSC_DIV out of range");
	end
	if (STARTUP_TICKS < 1 || SOFTSTART_TICKS < 1) begin : gBadTicks
		$error("delay counts must be at least one");
	end
	if (STARTUP_TICKS >= 2 ** CNT_W || SOFTSTART_TICKS >= 2 ** CNT_W) begin : gBadW
		$error("CNT_W too narrow for the delay counts");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] rstPinSync;
	logic [2:0] porSync;
	logic [2:0] tsdSync;
	logic extResetLow;
	logic porHeld;
	logic thermalShutdown;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPinSync <= 3'h0;
			porSync <= 3'h7;
			tsdSync <= 3'h0;
		end else begin
			rstPinSync <= {rstPinSync[1:0], external_reset_low_n};
			porSync <= {porSync[1:0], porActive};
			tsdSync <= {tsdSync[1:0], thermal_shutdown};
		end
	end

	// a level counts once the second and third stages agree
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			extResetLow <= 1'b1;
			porHeld <= 1'b1;
			thermalShutdown <= 1'b0;
		end else begin
			if (rstPinSync[1] == rstPinSync[2]) extResetLow <= !rstPinSync[2];
			if (porSync[1] == porSync[2]) porHeld <= porSync[2];
			if (tsdSync[1] == tsdSync[2]) thermalShutdown <= tsdSync[2];
		end
	end

	// ----------------------------------------
	// ahb-lite address phase capture
	// ----------------------------------------
	logic dpValid;
	logic dpWrite;
	logic [7:0] dpAddr;
	logic addrPhase;

	assign addrPhase = hsel && htrans[1] && hready;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dpValid <= 1'b0;
			dpWrite <= 1'b0;
			dpAddr <= 8'h00;
		end else if (hready) begin
			dpValid <= addrPhase;
			dpWrite <= addrPhase && hwrite;
			dpAddr <= addrPhase ? {haddr[7:2], 2'h0} : dpAddr;
		end
	end

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	pms_state_e state;
	pms_state_e next_state;
	logic runRequest;
	logic boostEnable;
	logic activeLoadEnable;
	logic boostEnPrev;
	logic [7:0] voutSetting;
	logic wrAccept;
	logic ctrlWr;
	logic voutWr;
	pms_conv_if convCv ();

	// writes are taken in every state except reset
	assign wrAccept = dpValid && dpWrite && state != PMS_RESET;
	assign ctrlWr = wrAccept && dpAddr == `PMS_CTRL_OFS;
	assign voutWr = wrAccept && dpAddr == `PMS_VOUT_OFS;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			runRequest <= 1'(`PMS_CTRL_RST >> `PMS_CTRL_RUN_BIT);
			boostEnable <= 1'b0;
			activeLoadEnable <= 1'b0;
		end else if (state == PMS_RESET) begin
			runRequest <= 1'b0;
			boostEnable <= 1'b0;
			activeLoadEnable <= 1'b0;
		end else if (ctrlWr) begin
			runRequest <= hwdata[`PMS_CTRL_RUN_BIT];
			boostEnable <= hwdata[`PMS_CTRL_BOOST_BIT];
			activeLoadEnable <= hwdata[`PMS_CTRL_ALOAD_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			voutSetting <= `PMS_VOUT_RST;
		end else if (state == PMS_RESET) begin
			voutSetting <= `PMS_VOUT_RST;
		end else if (voutWr) begin
			voutSetting <= hwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			boostEnPrev <= 1'b0;
		end else begin
			boostEnPrev <= boostEnable;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case ({haddr[7:2], 2'h0})
			`PMS_CTRL_OFS: begin
				rdMux[`PMS_CTRL_RUN_BIT] = runRequest;
				rdMux[`PMS_CTRL_BOOST_BIT] = boostEnable;
				rdMux[`PMS_CTRL_ALOAD_BIT] = activeLoadEnable;
			end
			`PMS_VOUT_OFS: begin
				rdMux[7:0] = voutSetting;
			end
			`PMS_STATUS_OFS: begin
				rdMux[2:0] = state;
				rdMux[3] = thermalShutdown;
				rdMux[4] = convCv.convRun;
				rdMux[5] = ledForceOff;
			end
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	// ----------------------------------------
	// oscillator tick
	// ----------------------------------------
	logic [7:0] oscCnt;
	logic oscTick;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oscCnt <= 8'h00;
		end else if (!refBiasOscEnable) begin
			oscCnt <= 8'h00;
		end else if (oscCnt == 8'(OSC_DIV - 1)) begin
			oscCnt <= 8'h00;
		end else begin
			oscCnt <= oscCnt + 8'h01;
		end
	end

	assign oscTick = refBiasOscEnable && oscCnt == 8'(OSC_DIV - 1);

	// ----------------------------------------
	// delay timer
	// ----------------------------------------
	logic timerStart;
	logic timerClear;
	logic timerDone;
	logic [CNT_W-1:0] timerLoad;

	// restart on entry to a timed state and while overheated
	assign timerStart = ((next_state == PMS_STARTUP || next_state == PMS_BOOST_SOFT)
		&& next_state != state) || (state == PMS_STARTUP && thermalShutdown);
	assign timerClear = next_state == PMS_RESET || next_state == PMS_STANDBY;
	assign timerLoad = (next_state == PMS_BOOST_SOFT) ? CNT_W'(SOFTSTART_TICKS)
		: CNT_W'(STARTUP_TICKS);

	pms_delay_timer #(
		.CNT_W(CNT_W)
	) uTimer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(timerStart),
		.clear(timerClear),
		.tick(oscTick),
		.loadTicks(timerLoad),
		.done(timerDone)
	);

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	logic inReset;
	logic boostRise;

	assign inReset = extResetLow || porHeld;
	assign boostRise = boostEnable && !boostEnPrev;

	always_comb begin
		next_state = state;
		case (state)
			PMS_RESET: begin
				next_state = PMS_STANDBY;
			end
			PMS_STANDBY: begin
				if (runRequest) next_state = PMS_STARTUP;
			end
			PMS_STARTUP: begin
				if (!runRequest) begin
					next_state = PMS_STANDBY;
				end else if (thermalShutdown) begin
					next_state = PMS_STARTUP;
				end else if (timerDone) begin
					next_state = boostEnable ? PMS_BOOST_SOFT : PMS_NORMAL;
				end
			end
			PMS_BOOST_SOFT: begin
				if (!runRequest) begin
					next_state = PMS_STANDBY;
				end else if (thermalShutdown) begin
					next_state = PMS_STARTUP;
				end else if (!boostEnable || timerDone) begin
					next_state = PMS_NORMAL;
				end
			end
			PMS_NORMAL: begin
				if (!runRequest) begin
					next_state = PMS_STANDBY;
				end else if (thermalShutdown) begin
					next_state = PMS_STARTUP;
				end else if (boostRise) begin
					next_state = PMS_BOOST_SOFT;
				end
			end
			default: begin
				next_state = PMS_RESET;
			end
		endcase
		if (inReset) next_state = PMS_RESET;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PMS_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// power control outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refBiasOscEnable <= 1'b0;
			chipEnable <= 1'b0;
			ledForceOff <= 1'b1;
		end else begin
			refBiasOscEnable <= next_state == PMS_STARTUP
				|| next_state == PMS_BOOST_SOFT
				|| next_state == PMS_NORMAL;
			chipEnable <= next_state == PMS_NORMAL;
			ledForceOff <= next_state != PMS_NORMAL;
		end
	end

	assign seqState = state;

	// ----------------------------------------
	// converter
	// ----------------------------------------
	assign convCv.oscTick = oscTick;
	assign convCv.convRun = next_state == PMS_BOOST_SOFT
		|| (next_state == PMS_NORMAL && boostEnable);
	assign convCv.softStart = next_state == PMS_BOOST_SOFT;
	assign convCv.activeLoadEn = activeLoadEnable;
	assign convCv.voutSetting = voutSetting;

	pms_boost_pwm #(
		.OSC_DIV(OSC_DIV)
	) uPwm (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cv(convCv.conv)
	);

	assign boostSwitch = convCv.switchOn;
	assign lowCurrentPwm = convCv.lowCurrent;
	assign activeLoadOn = convCv.activeLoadOn;
endmodule

//--- pms_regs.svh
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PMS_CTRL_OFS 8'h00
`define PMS_VOUT_OFS 8'h04
`define PMS_STATUS_OFS 8'h08
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PMS_CTRL_RUN_BIT 0
`define PMS_CTRL_BOOST_BIT 1
`define PMS_CTRL_ALOAD_BIT 2
`define PMS_CTRL_RST 3'h0
`define PMS_VOUT_RST 8'h08
`define PMS_VOUT_MIN 8'h08
`define PMS_VOUT_MAX 8'h14
// ----------------------------------------
// timing
// ----------------------------------------
`define PMS_REF_CLK_HZ 20000000
`define PMS_OSC_HZ 1000000
`define PMS_OSC_DIV (`PMS_REF_CLK_HZ / `PMS_OSC_HZ)
`define PMS_STARTUP_DELAY_US 10000
`define PMS_SOFTSTART_DELAY_US 20000
`define PMS_STARTUP_TICKS (`PMS_STARTUP_DELAY_US * (`PMS_OSC_HZ / 1000) / 1000)
`define PMS_SOFTSTART_TICKS (`PMS_SOFTSTART_DELAY_US * (`PMS_OSC_HZ / 1000) / 1000)
`define PMS_MIN_PULSE_PS 45000
`define PMS_MIN_PULSE_CYC ((`PMS_MIN_PULSE_PS * (`PMS_REF_CLK_HZ / 1000000) + 999999) / 1000000)
`define PMS_MAX_ON_CYC 16
`endif

//--- pms_pkg.sv
package pms_pkg;
	// ----------------------------------------
	// sequencer states, gray along the power-up path through soft-start
	// ----------------------------------------
	typedef enum logic [2:0] {
		PMS_RESET = 3'h0,
		PMS_STANDBY = 3'h1,
		PMS_STARTUP = 3'h3,
		PMS_BOOST_SOFT = 3'h2,
		PMS_NORMAL = 3'h6
	} pms_state_e;
endpackage

//--- pms_conv_if.sv
`timescale 1ns/1ps
interface pms_conv_if;
	logic oscTick;
	logic convRun;
	logic softStart;
	logic activeLoadEn;
	logic [7:0] voutSetting;
	logic switchOn;
	logic activeLoadOn;
	logic lowCurrent;
	modport seq (
		output oscTick, convRun, softStart, activeLoadEn, voutSetting,
		input switchOn, activeLoadOn, lowCurrent
	);
	modport conv (
		input oscTick, convRun, softStart, activeLoadEn, voutSetting,
		output switchOn, activeLoadOn, lowCurrent
	);
endinterface

//--- pms_delay_timer.sv
`timescale 1ns/1ps
module pms_delay_timer #(
	parameter int CNT_W = 15
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic clear,
	input wire logic tick,
	input wire logic [CNT_W-1:0] loadTicks,
	// status
	output logic done
);
	logic [CNT_W-1:0] count;
	logic armed;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
			count <= '0;
		end else if (clear) begin
			armed <= 1'b0;
			count <= '0;
		end else if (start) begin
			armed <= 1'b1;
			count <= loadTicks;
		end else if (armed && tick && count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign done = armed && (count == '0);
endmodule

//--- pms_boost_pwm.sv
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_boost_pwm #(
	parameter int OSC_DIV = `PMS_OSC_DIV
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// sequencer side
	pms_conv_if.conv cv
);
	localparam int PH_W = $clog2(OSC_DIV + 1);
	localparam logic [7:0] MIN_ON = 8'(`PMS_MIN_PULSE_CYC);
	localparam logic [7:0] MAX_ON = 8'(`PMS_MAX_ON_CYC);

	logic [PH_W-1:0] phase;
	logic [7:0] vCode;
	logic [7:0] onCycles;

	// out-of-range settings clamp to the end steps
	always_comb begin
		vCode = cv.voutSetting;
		if (vCode < `PMS_VOUT_MIN) vCode = `PMS_VOUT_MIN;
		if (vCode > `PMS_VOUT_MAX) vCode = `PMS_VOUT_MAX;
		onCycles = vCode - 8'h04;
		if (cv.softStart) onCycles = MIN_ON;
		if (onCycles > MAX_ON) onCycles = MAX_ON;
		if (onCycles < MIN_ON) onCycles = MIN_ON;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= '0;
		end else if (cv.oscTick) begin
			phase <= '0;
		end else if (phase < PH_W'(OSC_DIV)) begin
			phase <= phase + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cv.switchOn <= 1'b0;
			cv.lowCurrent <= 1'b0;
			cv.activeLoadOn <= 1'b0;
		end else begin
			// a pulse every switching cycle, never skipped
			cv.switchOn <= cv.convRun && (8'(phase) < onCycles);
			cv.lowCurrent <= cv.convRun && cv.softStart;
			cv.activeLoadOn <= cv.convRun && cv.activeLoadEn;
		end
	end
endmodule

//--- pms_power_mode_sequencer_chk.sv
`timescale 1ns/1ps
module pms_power_mode_sequencer_chk
	import pms_pkg::*;
#(
	parameter int OSC_DIV = 20,
	parameter int STARTUP_TICKS = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// bus and pins
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic external_reset_low_n,
	input wire logic porActive,
	input wire logic thermal_shutdown,
	// power outputs
	input wire logic refBiasOscEnable,
	input wire logic chipEnable,
	input wire logic ledForceOff,
	input wire logic boostSwitch,
	input wire logic lowCurrentPwm,
	input wire logic activeLoadOn,
	input wire logic [2:0] seqState
);
	int stCnt;
	int onCnt;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// cycles spent in startup, consecutive switch-on cycles
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			stCnt <= 0;
		else if (seqState == PMS_STARTUP)
			stCnt <= stCnt + 1;
		else
			stCnt <= 0;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			onCnt <= 0;
		else if (boostSwitch)
			onCnt <= onCnt + 1;
		else
			onCnt <= 0;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_bus;
		hreadyout && !hresp;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
	property p_chip;
		chipEnable == (seqState == PMS_NORMAL) && ledForceOff == (seqState != PMS_NORMAL);
	endproperty
	a_chip: assert property (p_chip) else $error("chip enable or led off wrong");
	property p_stby;
		(seqState == PMS_RESET || seqState == PMS_STANDBY) |->
			!refBiasOscEnable && !boostSwitch && !activeLoadOn && !lowCurrentPwm;
	endproperty
	a_stby: assert property (p_stby) else $error("circuit active in standby");
	property p_low;
		lowCurrentPwm |-> seqState == PMS_BOOST_SOFT;
	endproperty
	a_low: assert property (p_low) else $error("low current mode outside soft start");
	property p_rstSeq;
		$past(seqState) == PMS_RESET |-> seqState == PMS_RESET || seqState == PMS_STANDBY;
	endproperty
	a_rstSeq: assert property (p_rstSeq) else $error("reset not followed by standby");
	property p_pin;
		!external_reset_low_n [*8] |-> seqState == PMS_RESET;
	endproperty
	a_pin: assert property (p_pin) else $error("reset pin low but not in reset");
	property p_por;
		porActive [*8] |-> seqState == PMS_RESET;
	endproperty
	a_por: assert property (p_por) else $error("power on reset but not in reset");
	property p_tsd;
		thermal_shutdown [*8] |-> seqState != PMS_BOOST_SOFT && seqState != PMS_NORMAL;
	endproperty
	a_tsd: assert property (p_tsd) else $error("operating during thermal event");
	property p_stDly;
		seqState == PMS_STARTUP && stCnt < (STARTUP_TICKS - 1) * OSC_DIV |=>
			seqState != PMS_BOOST_SOFT && seqState != PMS_NORMAL;
	endproperty
	a_stDly: assert property (p_stDly) else $error("startup delay cut short");
	property p_onMax;
		boostSwitch |-> onCnt < 16;
	endproperty
	a_onMax: assert property (p_onMax) else $error("switch on time over limit");
	property p_run;
		seqState == PMS_STARTUP |-> refBiasOscEnable;
	endproperty
	a_run: assert property (p_run) else $error("startup without reference enable");
endmodule
bind pms_power_mode_sequencer pms_power_mode_sequencer_chk #(
	.OSC_DIV(OSC_DIV),
	.STARTUP_TICKS(STARTUP_TICKS)
) u_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.external_reset_low_n(external_reset_low_n),
	.porActive(porActive),
	.thermal_shutdown(thermal_shutdown),
	.refBiasOscEnable(refBiasOscEnable),
	.chipEnable(chipEnable),
	.ledForceOff(ledForceOff),
	.boostSwitch(boostSwitch),
	.lowCurrentPwm(lowCurrentPwm),
	.activeLoadOn(activeLoadOn),
	.seqState(seqState)
);

//--- tb_power_mode_sequencer.sv
`timescale 1ns/1ps
`include "pms_regs.svh"
module tb_power_mode_sequencer
	import pms_pkg::*;
;
	localparam int DIV = 20;
	localparam int ST = 20;
	localparam int SS = 40;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic take = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] v;
	logic hready, hreadyout, hresp, boostSwitch;
	logic external_reset_low_n = 1'b1;
	logic porActive = 1'b0;
	logic thermal_shutdown = 1'b0;
	logic refBiasOscEnable, chipEnable, ledForceOff, lowCurrentPwm, activeLoadOn;
	logic [2:0] seqState;
	logic [32:0] expQ[$];
	int err_count = 0;
	int n_compared = 0;
	int seed = 25;
	int n;
	wire [7:0] portVec = {activeLoadOn, lowCurrentPwm, chipEnable, ledForceOff,
		refBiasOscEnable, seqState};
	assign hready = hreadyout;
	always #25 ref_clk = ~ref_clk;
	pms_power_mode_sequencer #(.OSC_DIV(DIV), .STARTUP_TICKS(ST), .SOFTSTART_TICKS(SS)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .external_reset_low_n(external_reset_low_n),
		.porActive(porActive), .thermal_shutdown(thermal_shutdown),
		.refBiasOscEnable(refBiasOscEnable), .chipEnable(chipEnable),
		.ledForceOff(ledForceOff), .boostSwitch(boostSwitch), .lowCurrentPwm(lowCurrentPwm),
		.activeLoadOn(activeLoadOn), .seqState(seqState));
	// ----------------------------------------
	// monitor: oldest note against read data or pins
	// ----------------------------------------
	always @(posedge ref_clk) begin
		logic [32:0] e;
		logic [31:0] seen;
		if (take === 1'b1) begin
			e = expQ.pop_front();
			seen = e[32] ? {24'h0, portVec} : hrdata;
			n_compared++;
			if (seen !== e[31:0]) begin
				err_count++;
				$display("ERROR %s expected %h seen %h", e[32] ? "pins" : "hrdata", e[31:0], seen);
			end
		end
	end
	// ----------------------------------------
	// drivers and helpers
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		if (wr)
			hwdata <= d;
		else begin
			expQ.push_back({1'b0, d});
			take <= 1'b1;
		end
		do @(posedge ref_clk); while (hready !== 1'b1);
		take <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic chk(input logic [7:0] p);
		expQ.push_back({1'b1, 24'h0, p});
		take <= 1'b1;
		@(posedge ref_clk);
		take <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic near(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("ERROR count expected %0d..%0d seen %0d", lo, hi, got);
		end
	endtask
	// wait until state reached, or until it is left when lv is set
	task automatic waitSt(input logic [2:0] s, input logic lv, input int lim);
		n = 0;
		while ((lv ? seqState === s : seqState !== s) && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		near(n, 0, lim - 1);
	endtask
	task automatic cntPulse();
		logic last;
		last = boostSwitch;
		n = 0;
		repeat (4 * DIV) begin
			@(posedge ref_clk);
			if (boostSwitch === 1'b1 && last !== 1'b1)
				n++;
			last = boostSwitch;
		end
	endtask
	task automatic results();
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge ref_clk);
		err_count++;
		results();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		waitSt(PMS_STANDBY, 1'b0, 40);
		chk(8'h11);
		bus(1'b0, `PMS_CTRL_OFS, 32'h0);
		bus(1'b0, `PMS_VOUT_OFS, 32'h8);
		bus(1'b0, `PMS_STATUS_OFS, 32'h21);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & 32'hFF;
			bus(1'b1, `PMS_VOUT_OFS, v);
			bus(1'b0, `PMS_VOUT_OFS, v);
		end
		bus(1'b1, `PMS_VOUT_OFS, 32'hFF);
		bus(1'b1, `PMS_STATUS_OFS, 32'hFFFFFFFF);
		bus(1'b0, `PMS_STATUS_OFS, 32'h21);
		bus(1'b1, 8'h0C, $random(seed));
		bus(1'b0, 8'h0C, 32'h0);
		bus(1'b1, `PMS_CTRL_OFS, 32'h6);
		bus(1'b0, `PMS_CTRL_OFS, 32'h6);
		chk(8'h11);
		bus(1'b1, `PMS_CTRL_OFS, 32'h7);
		waitSt(PMS_STARTUP, 1'b0, 20);
		waitSt(PMS_STARTUP, 1'b1, (ST + 4) * DIV);
		near(n, (ST - 1) * DIV, (ST + 2) * DIV);
		near(seqState === PMS_BOOST_SOFT, 1, 1);
		@(posedge ref_clk);
		near(lowCurrentPwm === 1'b1 && ledForceOff === 1'b1, 1, 1);
		waitSt(PMS_BOOST_SOFT, 1'b1, (SS + 4) * DIV);
		near(n, (SS - 2) * DIV, (SS + 2) * DIV);
		near(seqState === PMS_NORMAL, 1, 1);
		repeat (2) @(posedge ref_clk);
		chk(8'hAE);
		cntPulse();
		near(n, 3, 5);
		bus(1'b0, `PMS_STATUS_OFS, 32'h16);
		bus(1'b1, `PMS_CTRL_OFS, 32'h3);
		chk(8'h2E);
		bus(1'b1, `PMS_CTRL_OFS, 32'h1);
		bus(1'b1, `PMS_VOUT_OFS, 32'h8);
		repeat (2) @(posedge ref_clk);
		cntPulse();
		near(n, 0, 0);
		chk(8'h2E);
		bus(1'b1, `PMS_CTRL_OFS, 32'h3);
		waitSt(PMS_BOOST_SOFT, 1'b0, 6);
		waitSt(PMS_BOOST_SOFT, 1'b1, (SS + 4) * DIV);
		thermal_shutdown <= 1'b1;
		waitSt(PMS_STARTUP, 1'b0, 10);
		repeat ((ST + 4) * DIV) @(posedge ref_clk);
		chk(8'h1B);
		thermal_shutdown <= 1'b0;
		waitSt(PMS_STARTUP, 1'b1, (ST + 8) * DIV);
		near(n, (ST - 1) * DIV, (ST + 8) * DIV);
		waitSt(PMS_BOOST_SOFT, 1'b1, (SS + 4) * DIV);
		bus(1'b1, `PMS_CTRL_OFS, 32'h0);
		waitSt(PMS_STANDBY, 1'b0, 10);
		bus(1'b1, `PMS_CTRL_OFS, 32'h1);
		waitSt(PMS_STARTUP, 1'b0, 10);
		chk(8'h1B);
		waitSt(PMS_STARTUP, 1'b1, (ST + 4) * DIV);
		near(seqState === PMS_NORMAL, 1, 1);
		external_reset_low_n <= 1'b0;
		waitSt(PMS_RESET, 1'b0, 10);
		chk(8'h10);
		external_reset_low_n <= 1'b1;
		waitSt(PMS_STANDBY, 1'b0, 20);
		bus(1'b0, `PMS_CTRL_OFS, 32'h0);
		bus(1'b1, `PMS_VOUT_OFS, 32'hFF);
		bus(1'b1, `PMS_CTRL_OFS, 32'h1);
		waitSt(PMS_STARTUP, 1'b0, 10);
		porActive <= 1'b1;
		waitSt(PMS_RESET, 1'b0, 10);
		chk(8'h10);
		porActive <= 1'b0;
		waitSt(PMS_STANDBY, 1'b0, 20);
		bus(1'b0, `PMS_VOUT_OFS, 32'h8);
		results();
	end
endmodule
